// ### core/dpt_timer.sv
// Dual 8-bit programmable down-counting timer with prescalers, wave output and serial clock.
`timescale 1ns/10ps

module dpt_timer
  import dpt_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int NUM_TIMERS = 2,
  parameter int COUNT_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [3:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [3:0] rdata,
  input wire logic low_speed_osc,
  input wire logic high_speed_osc,
  input wire logic event_input_pin,
  output logic shared_output_pin,
  output logic timer_wave_out,
  output logic serial_clk,
  output logic t0_irq_req,
  output logic t1_irq_req,
  output logic t0_irq_flag,
  output logic t1_irq_flag
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // The oscillators and the event pin are foreign to clk, so each passes
  // two flops; a third stage serves only the edge detectors.
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] rise;
  logic [2:0] fall;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
    end else begin
      sync1_reg <= {event_input_pin, high_speed_osc, low_speed_osc};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~sync3_reg;
  assign fall = ~sync2_reg & sync3_reg;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic event_mode_reg;
  logic filter_sel_reg;
  logic edge_pol_reg;
  logic wave_channel_select_reg;
  logic wave_output_enable_reg;
  logic [NUM_TIMERS-1:0] source_select_reg;
  logic [NUM_TIMERS-1:0] run_reg;
  logic [1:0] ratio_reg [NUM_TIMERS];
  logic [COUNT_W-1:0] reload_reg [NUM_TIMERS];
  logic [COUNT_W-1:0] count_reg [NUM_TIMERS];
  logic [3:0] hold_hi_reg [NUM_TIMERS];
  logic [7:0] presc_reg [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] irq_mask_reg;
  logic [NUM_TIMERS-1:0] irq_flag_reg;
  logic wave_toggle_reg;
  logic serial_toggle_reg;
  logic [3:0] rdata_reg;
  logic shared_pin_reg;
  logic [1:0] irq_req_reg;

  // Decoded bus strobes and count-path signals.
  logic [NUM_TIMERS-1:0] ctrl_wr;
  logic [NUM_TIMERS-1:0] reload_lo_wr;
  logic [NUM_TIMERS-1:0] reload_hi_wr;
  logic [NUM_TIMERS-1:0] count_lo_rd;
  logic [NUM_TIMERS-1:0] reload_strobe;
  logic [NUM_TIMERS-1:0] src_edge;
  logic [NUM_TIMERS-1:0] presc_done;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] underflow;
  logic [7:0] presc_last [NUM_TIMERS];
  logic event_edge;
  logic wave_src_uf;

  localparam logic [15:0] CTRL_BASE [2] = '{DPT_TIMER0_CONTROL_ADDR, DPT_TIMER1_CONTROL_ADDR};
  localparam logic [15:0] RLO_BASE [2] = '{DPT_TIMER0_RELOAD_LOW_ADDR, DPT_TIMER1_RELOAD_LOW_ADDR};
  localparam logic [15:0] RHI_BASE [2] = '{DPT_TIMER0_RELOAD_HIGH_ADDR, DPT_TIMER1_RELOAD_HIGH_ADDR};
  localparam logic [15:0] CLO_BASE [2] = '{DPT_TIMER0_COUNT_LOW_ADDR, DPT_TIMER1_COUNT_LOW_ADDR};

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      ctrl_wr[i] = wr && (addr == CTRL_BASE[i]);
      reload_lo_wr[i] = wr && (addr == RLO_BASE[i]);
      reload_hi_wr[i] = wr && (addr == RHI_BASE[i]);
      count_lo_rd[i] = rd && (addr == CLO_BASE[i]);
      reload_strobe[i] = ctrl_wr[i] && wdata[DPT_CTRL_STROBE_BIT];
    end
  end

  // ****************************************************************
  // Prescalers and count clocks
  // ****************************************************************
  // Event counting is a bare edge detector on the synchronised pin; the
  // noise filter select is stored and read back but not acted on here.
  assign event_edge = edge_pol_reg ? rise[2] : fall[2];

  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      src_edge[i] = source_select_reg[i] ? rise[1] : rise[0];
      unique case (dpt_ratio_e'(ratio_reg[i]))
        DPT_RATIO_DIV1: presc_last[i] = DPT_PRESC_LAST_DIV1;
        DPT_RATIO_DIV4: presc_last[i] = DPT_PRESC_LAST_DIV4;
        DPT_RATIO_DIV32: presc_last[i] = DPT_PRESC_LAST_DIV32;
        DPT_RATIO_DIV256: presc_last[i] = DPT_PRESC_LAST_DIV256;
      endcase
      presc_done[i] = src_edge[i] && (presc_reg[i] == presc_last[i]);
      tick[i] = run_reg[i] && presc_done[i];
    end
    if (event_mode_reg) begin
      tick[0] = run_reg[0] && event_edge;
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      underflow[i] = tick[i] && !reload_strobe[i] && (count_reg[i] == DPT_BYTE_RESET);
    end
  end

  // A prescaler restarts on the reload strobe so the first period after a
  // preset is a whole one; it holds while the timer is stopped.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        presc_reg[i] <= DPT_BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (reload_strobe[i]) begin
          presc_reg[i] <= DPT_BYTE_RESET;
        end else if (run_reg[i] && src_edge[i]) begin
          if (presc_done[i]) begin
            presc_reg[i] <= DPT_BYTE_RESET;
          end else begin
            presc_reg[i] <= presc_reg[i] + 8'h01;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Down counters
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        count_reg[i] <= DPT_BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (reload_strobe[i]) begin
          count_reg[i] <= reload_reg[i];
        end else if (underflow[i]) begin
          count_reg[i] <= reload_reg[i];
        end else if (tick[i]) begin
          count_reg[i] <= count_reg[i] - 8'h01;
        end
      end
    end
  end

  // Reading the low nibble freezes the high nibble so a borrow between the
  // two reads cannot tear the value.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        hold_hi_reg[i] <= DPT_NIBBLE_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (count_lo_rd[i]) begin
          hold_hi_reg[i] <= count_reg[i][7:4];
        end
      end
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      event_mode_reg <= 1'b0;
      filter_sel_reg <= 1'b0;
      edge_pol_reg <= 1'b0;
    end else if (wr && addr == DPT_COUNTER_MODE_CTRL_ADDR) begin
      event_mode_reg <= wdata[DPT_MODE_EVENT_BIT];
      filter_sel_reg <= wdata[DPT_MODE_FILT_BIT];
      edge_pol_reg <= wdata[DPT_MODE_POL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wave_channel_select_reg <= 1'b0;
      wave_output_enable_reg <= 1'b0;
      source_select_reg <= '0;
    end else if (wr && addr == DPT_WAVE_OUT_AND_SOURCE_CTRL_ADDR) begin
      wave_channel_select_reg <= wdata[DPT_WAVE_CHAN_BIT];
      wave_output_enable_reg <= wdata[DPT_WAVE_EN_BIT];
      source_select_reg[0] <= wdata[DPT_SRC_T0_BIT];
      source_select_reg[1] <= wdata[DPT_SRC_T1_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_reg <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ratio_reg[i] <= DPT_RATIO_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (ctrl_wr[i]) begin
          run_reg[i] <= wdata[DPT_CTRL_RUN_BIT];
          ratio_reg[i] <= wdata[DPT_CTRL_RATIO_MSB:DPT_CTRL_RATIO_LSB];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        reload_reg[i] <= DPT_BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (reload_lo_wr[i]) begin
          reload_reg[i][3:0] <= wdata;
        end
        if (reload_hi_wr[i]) begin
          reload_reg[i][7:4] <= wdata;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_mask_reg <= '0;
    end else if (wr && addr == DPT_IRQ_MASK_ADDR) begin
      irq_mask_reg <= wdata[NUM_TIMERS-1:0];
    end
  end

  // Flags clear by writing 1; an underflow in the same cycle wins.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_flag_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (underflow[i]) begin
          irq_flag_reg[i] <= 1'b1;
        end else if (wr && addr == DPT_IRQ_FLAG_ADDR && wdata[i]) begin
          irq_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Request follows the flag one cycle later, gated by the mask only.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_req_reg <= 2'h0;
    end else begin
      irq_req_reg <= irq_flag_reg & irq_mask_reg;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= DPT_NIBBLE_RESET;
    end else if (rd) begin
      unique case (addr)
        DPT_COUNTER_MODE_CTRL_ADDR:
          rdata_reg <= {1'b0, event_mode_reg, filter_sel_reg, edge_pol_reg};
        DPT_WAVE_OUT_AND_SOURCE_CTRL_ADDR:
          rdata_reg <= {wave_channel_select_reg, wave_output_enable_reg, source_select_reg[1],
                        source_select_reg[0]};
        DPT_TIMER0_CONTROL_ADDR:
          rdata_reg <= {ratio_reg[0], 1'b0, run_reg[0]};
        DPT_TIMER1_CONTROL_ADDR:
          rdata_reg <= {ratio_reg[1], 1'b0, run_reg[1]};
        DPT_TIMER0_RELOAD_LOW_ADDR: rdata_reg <= reload_reg[0][3:0];
        DPT_TIMER0_RELOAD_HIGH_ADDR: rdata_reg <= reload_reg[0][7:4];
        DPT_TIMER1_RELOAD_LOW_ADDR: rdata_reg <= reload_reg[1][3:0];
        DPT_TIMER1_RELOAD_HIGH_ADDR: rdata_reg <= reload_reg[1][7:4];
        DPT_TIMER0_COUNT_LOW_ADDR: rdata_reg <= count_reg[0][3:0];
        DPT_TIMER0_COUNT_HIGH_ADDR: rdata_reg <= hold_hi_reg[0];
        DPT_TIMER1_COUNT_LOW_ADDR: rdata_reg <= count_reg[1][3:0];
        DPT_TIMER1_COUNT_HIGH_ADDR: rdata_reg <= hold_hi_reg[1];
        DPT_IRQ_MASK_ADDR: rdata_reg <= {2'h0, irq_mask_reg};
        DPT_IRQ_FLAG_ADDR: rdata_reg <= {2'h0, irq_flag_reg};
        default: rdata_reg <= DPT_NIBBLE_RESET;
      endcase
    end else begin
      rdata_reg <= DPT_NIBBLE_RESET;
    end
  end

  // ****************************************************************
  // Wave output and serial clock
  // ****************************************************************
  assign wave_src_uf = wave_channel_select_reg ? underflow[1] : underflow[0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wave_toggle_reg <= 1'b0;
    end else if (wave_src_uf) begin
      wave_toggle_reg <= ~wave_toggle_reg;
    end
  end

  // The serial clock has its own toggle so it runs with timer 1 whatever
  // the channel select and the output enable say.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serial_toggle_reg <= 1'b0;
    end else if (underflow[1]) begin
      serial_toggle_reg <= ~serial_toggle_reg;
    end
  end

  // Enable gating is not aligned to the waveform, so a shortened first or
  // last half period may appear on the pin when it is switched.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shared_pin_reg <= 1'b1;
    end else begin
      shared_pin_reg <= wave_output_enable_reg ? wave_toggle_reg : 1'b1;
    end
  end

  assign rdata = rdata_reg;
  assign shared_output_pin = shared_pin_reg;
  assign timer_wave_out = wave_toggle_reg;
  assign serial_clk = serial_toggle_reg;
  assign t0_irq_req = irq_req_reg[0];
  assign t1_irq_req = irq_req_reg[1];
  assign t0_irq_flag = irq_flag_reg[0];
  assign t1_irq_flag = irq_flag_reg[1];

endmodule // dpt_timer

// ### pkg/dpt_pkg.sv
// Package with register map, field positions and constants of the dual programmable timer.
package dpt_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [15:0] DPT_COUNTER_MODE_CTRL_ADDR = 16'hFFC0;
  localparam logic [15:0] DPT_WAVE_OUT_AND_SOURCE_CTRL_ADDR = 16'hFFC1;
  localparam logic [15:0] DPT_TIMER0_CONTROL_ADDR = 16'hFFC2;
  localparam logic [15:0] DPT_TIMER1_CONTROL_ADDR = 16'hFFC3;
  localparam logic [15:0] DPT_TIMER0_RELOAD_LOW_ADDR = 16'hFFC4;
  localparam logic [15:0] DPT_TIMER0_RELOAD_HIGH_ADDR = 16'hFFC5;
  localparam logic [15:0] DPT_TIMER1_RELOAD_LOW_ADDR = 16'hFFC6;
  localparam logic [15:0] DPT_TIMER1_RELOAD_HIGH_ADDR = 16'hFFC7;
  localparam logic [15:0] DPT_TIMER0_COUNT_LOW_ADDR = 16'hFFC8;
  localparam logic [15:0] DPT_TIMER0_COUNT_HIGH_ADDR = 16'hFFC9;
  localparam logic [15:0] DPT_TIMER1_COUNT_LOW_ADDR = 16'hFFCA;
  localparam logic [15:0] DPT_TIMER1_COUNT_HIGH_ADDR = 16'hFFCB;
  localparam logic [15:0] DPT_IRQ_MASK_ADDR = 16'hFFE2;
  localparam logic [15:0] DPT_IRQ_FLAG_ADDR = 16'hFFF2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DPT_MODE_POL_BIT = 0;
  localparam int DPT_MODE_FILT_BIT = 1;
  localparam int DPT_MODE_EVENT_BIT = 2;
  localparam int DPT_SRC_T0_BIT = 0;
  localparam int DPT_SRC_T1_BIT = 1;
  localparam int DPT_WAVE_EN_BIT = 2;
  localparam int DPT_WAVE_CHAN_BIT = 3;
  localparam int DPT_CTRL_RUN_BIT = 0;
  localparam int DPT_CTRL_STROBE_BIT = 1;
  localparam int DPT_CTRL_RATIO_LSB = 2;
  localparam int DPT_CTRL_RATIO_MSB = 3;

  // ****************************************************************
  // Reset values and prescaler terminal counts
  // ****************************************************************
  localparam logic [3:0] DPT_NIBBLE_RESET = 4'h0;
  localparam logic [7:0] DPT_BYTE_RESET = 8'h00;
  localparam logic [1:0] DPT_RATIO_RESET = 2'h0;
  localparam logic [7:0] DPT_PRESC_LAST_DIV1 = 8'h00;
  localparam logic [7:0] DPT_PRESC_LAST_DIV4 = 8'h03;
  localparam logic [7:0] DPT_PRESC_LAST_DIV32 = 8'h1F;
  localparam logic [7:0] DPT_PRESC_LAST_DIV256 = 8'hFF;

  typedef enum logic [1:0] {
    DPT_RATIO_DIV1,
    DPT_RATIO_DIV4,
    DPT_RATIO_DIV32,
    DPT_RATIO_DIV256
  } dpt_ratio_e;

endpackage

// ### test/dpt_osc_model.sv
// Oscillator model driving the two source clock pins of the timer.
`timescale 1ns/10ps
module dpt_osc_model #(
  parameter int LO_HALF = 40,
  parameter int HI_HALF = 24
) (
  input wire logic hi_on,
  output logic low_speed_osc,
  output logic high_speed_osc
);
  initial begin
    low_speed_osc = 1'b0;
    forever #(LO_HALF) low_speed_osc = ~low_speed_osc;
  end

  // The fast oscillator is still while switched off, so a timer fed by it must not count.
  initial begin
    high_speed_osc = 1'b0;
    forever begin
      #(HI_HALF);
      high_speed_osc = hi_on ? ~high_speed_osc : 1'b0;
    end
  end
endmodule // dpt_osc_model

// ### test/dpt_timer_assertions.sv
// Concurrent checks on the ports of the dual programmable timer.
`timescale 1ns/10ps
module dpt_timer_assertions
  import dpt_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [3:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] rdata,
  input wire logic shared_output_pin,
  input wire logic timer_wave_out,
  input wire logic serial_clk,
  input wire logic t0_irq_req,
  input wire logic t1_irq_req,
  input wire logic t0_irq_flag,
  input wire logic t1_irq_flag
);
  // ****************************************************************
  // Shadow copies of the software-written controls
  // ****************************************************************
  logic [3:0] src_reg;
  logic [1:0] mask_reg;
  logic [2:0] en_hist_reg;

  always_ff @(posedge clk) begin
    if (!nrst) src_reg <= DPT_NIBBLE_RESET;
    else if (wr && addr == DPT_WAVE_OUT_AND_SOURCE_CTRL_ADDR) src_reg <= wdata;
  end

  always_ff @(posedge clk) begin
    if (!nrst) mask_reg <= 2'h0;
    else if (wr && addr == DPT_IRQ_MASK_ADDR) mask_reg <= wdata[1:0];
  end

  // The pin is only judged once the enable has been off long enough for the registered path to settle.
  always_ff @(posedge clk) begin
    if (!nrst) en_hist_reg <= 3'h0;
    else en_hist_reg <= {en_hist_reg[1:0], src_reg[DPT_WAVE_EN_BIT]};
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_mode_top_zero: assert property (
    rd && addr == DPT_COUNTER_MODE_CTRL_ADDR |=> rdata[3] == 1'b0) else $error("mode register top bit not zero");
  a_strobe_reads_zero: assert property (
    rd && (addr == DPT_TIMER0_CONTROL_ADDR || addr == DPT_TIMER1_CONTROL_ADDR) |=> !rdata[DPT_CTRL_STROBE_BIT])
    else $error("reload strobe bit read back as one");
  a_src_readback: assert property (
    rd && addr == DPT_WAVE_OUT_AND_SOURCE_CTRL_ADDR |=> rdata == $past(src_reg))
    else $error("output control readback");
  a_req_t0_mask: assert property (
    t0_irq_req == ($past(t0_irq_flag) && $past(mask_reg[0]))) else $error("timer 0 request not flag and mask");
  a_req_t1_mask: assert property (
    t1_irq_req == ($past(t1_irq_flag) && $past(mask_reg[1]))) else $error("timer 1 request not flag and mask");
  a_wave_chan_flag: assert property (
    $changed(timer_wave_out) |-> ($past(src_reg[DPT_WAVE_CHAN_BIT]) ? t1_irq_flag : t0_irq_flag))
    else $error("wave toggled without selected underflow");
  a_serial_t1_flag: assert property (
    $changed(serial_clk) |-> t1_irq_flag) else $error("serial clock toggled without timer 1 underflow");
  a_pin_high_off: assert property (
    !src_reg[DPT_WAVE_EN_BIT] && en_hist_reg == 3'h0 |-> shared_output_pin) else $error("pin low while disabled");
  a_toggles_reset_low: assert property (
    $rose(nrst) |-> !timer_wave_out && !serial_clk) else $error("toggle flops not low after reset");

  c_req: cover property (t0_irq_req);
  c_pin_wave: cover property ($fell(shared_output_pin));
  c_count_high: cover property (rd && addr == DPT_TIMER1_COUNT_HIGH_ADDR);
endmodule // dpt_timer_assertions

// ### test/test_dpt_timer.sv
// Self-checking testbench for the dual programmable timer.
`timescale 1ns/10ps
module test_dpt_timer
  import dpt_pkg::*;
;
  logic clk, nrst, wr, rd, hi_on, event_input_pin;
  logic [15:0] addr;
  logic [3:0] wdata, rdata;
  logic low_speed_osc, high_speed_osc, shared_output_pin, timer_wave_out, serial_clk;
  logic t0_irq_req, t1_irq_req, t0_irq_flag, t1_irq_flag;
  int n_mismatch, n_tests, n_lo, n_hi, n_wv, n_sc, n_pl;
  int dv[4] = '{1, 4, 32, 256};

  dpt_osc_model osc (.hi_on(hi_on), .low_speed_osc(low_speed_osc), .high_speed_osc(high_speed_osc));
  dpt_timer uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .low_speed_osc(low_speed_osc), .high_speed_osc(high_speed_osc), .event_input_pin(event_input_pin),
    .shared_output_pin(shared_output_pin), .timer_wave_out(timer_wave_out), .serial_clk(serial_clk),
    .t0_irq_req(t0_irq_req), .t1_irq_req(t1_irq_req), .t0_irq_flag(t0_irq_flag), .t1_irq_flag(t1_irq_flag));

  always @(posedge low_speed_osc) n_lo++;
  always @(posedge high_speed_osc) n_hi++;
  always @(timer_wave_out) n_wv++;
  always @(serial_clk) n_sc++;
  always @(negedge shared_output_pin) n_pl++;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************************************
  // Bus cycles and comparison
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [3:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [3:0] e);
    logic [3:0] d;
    rd_reg(a, d);
    chk(16'(d), 16'(e));
  endtask

  task automatic wait_uf(input int t, input logic hs, output int c);
    int k;
    k = 0;
    #1;
    while ((t == 1 ? t1_irq_flag : t0_irq_flag) !== 1'b1 && k < 30000) begin
      @(posedge clk);
      k++;
    end
    c = hs ? n_hi : n_lo;
    chk(16'(k < 30000), 16'h1);
    wr_reg(16'hFFF2, 4'h3);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic period(input int t, input logic [3:0] src, input logic [1:0] ra, input logic [7:0] rl, input int e);
    int a0, a1;
    wr_reg(16'hFFC1, src);
    wr_reg(16'hFFC4 + 16'(2 * t), rl[3:0]);
    wr_reg(16'hFFC5 + 16'(2 * t), rl[7:4]);
    wr_reg(16'hFFF2, 4'h3);
    wr_reg(16'hFFC2 + 16'(t), {ra, 2'b11});
    wait_uf(t, src[t], a0);
    wait_uf(t, src[t], a1);
    wr_reg(16'hFFC2 + 16'(t), 4'h0);
    chk(16'(a1 - a0), 16'(e));
  endtask

  task automatic t_regs;
    for (int i = 0; i < 12; i++) rchk(16'hFFC0 + 16'(i), 4'h0);
    rchk(16'hFFE2, 4'h0);
    wr_reg(16'hFFC0, 4'hF);
    rchk(16'hFFC0, 4'h7);
    wr_reg(16'hFFC0, 4'h0);
    wr_reg(16'hFFC1, 4'hB);
    rchk(16'hFFC1, 4'hB);
    wr_reg(16'hFFC2, 4'hE);
    rchk(16'hFFC2, 4'hC);
    for (int i = 4; i < 8; i++) wr_reg(16'hFFC0 + 16'(i), 4'(i + 5));
    for (int i = 4; i < 8; i++) rchk(16'hFFC0 + 16'(i), 4'(i + 5));
    wr_reg(16'hFFC8, 4'h9);
    rchk(16'hFFC8, 4'h0);
    rchk(16'h1234, 4'h0);
    wr_reg(16'hFFC1, 4'h0);
    wr_reg(16'hFFC2, 4'h0);
  endtask

  task automatic t_irq;
    wr_reg(16'hFFC1, 4'h0);
    wr_reg(16'hFFE2, 4'h1);
    wr_reg(16'hFFC2, 4'h3);
    wr_reg(16'hFFC3, 4'h3);
    repeat (100) @(posedge clk);
    wr_reg(16'hFFC2, 4'h0);
    wr_reg(16'hFFC3, 4'h0);
    #1;
    chk(16'({t0_irq_flag, t1_irq_flag, t0_irq_req, t1_irq_req}), 16'hE);
    rchk(16'hFFF2, 4'h3);
    wr_reg(16'hFFF2, 4'h3);
    rchk(16'hFFF2, 4'h0);
    wr_reg(16'hFFE2, 4'h0);
  endtask

  task automatic t_hold;
    logic [3:0] l0, h0, l1, h1;
    wr_reg(16'hFFC6, 4'h5);
    wr_reg(16'hFFC7, 4'hA);
    wr_reg(16'hFFC3, 4'h2);
    rchk(16'hFFCA, 4'h5);
    wr_reg(16'hFFC7, 4'h3);
    wr_reg(16'hFFC3, 4'h2);
    rchk(16'hFFCB, 4'hA);
    rchk(16'hFFCA, 4'h5);
    rchk(16'hFFCB, 4'h3);
    wr_reg(16'hFFC3, 4'h1);
    repeat (50) @(posedge clk);
    wr_reg(16'hFFC3, 4'h0);
    rd_reg(16'hFFCA, l0);
    rd_reg(16'hFFCB, h0);
    repeat (200) @(posedge clk);
    rd_reg(16'hFFCA, l1);
    rd_reg(16'hFFCB, h1);
    chk({8'h00, h1, l1}, {8'h00, h0, l0});
    chk(16'({h0, l0} < 8'h35), 16'h1);
  endtask

  // Rising polarity first, then falling, so both edge selections count.
  task automatic t_event;
    for (int p = 1; p >= 0; p--) begin
      wr_reg(16'hFFC0, 4'(4 + p));
      wr_reg(16'hFFC1, 4'h1);
      wr_reg(16'hFFC4, 4'h1);
      wr_reg(16'hFFC5, 4'h0);
      wr_reg(16'hFFF2, 4'h3);
      wr_reg(16'hFFC2, 4'h3);
      repeat (2) begin
        repeat (29) @(posedge clk);
        #1 chk(16'(t0_irq_flag), 16'h0);
        @(posedge clk);
        event_input_pin <= 1'b1;
        repeat (20) @(posedge clk);
        event_input_pin <= 1'b0;
      end
      repeat (6) @(posedge clk);
      #1 chk(16'(t0_irq_flag), 16'h1);
    end
    wr_reg(16'hFFC2, 4'h0);
    wr_reg(16'hFFC0, 4'h0);
  endtask

  task automatic t_wave;
    int w0, s0, p0;
    wr_reg(16'hFFC6, 4'h0);
    wr_reg(16'hFFC7, 4'h0);
    wr_reg(16'hFFC1, 4'h8);
    wr_reg(16'hFFC3, 4'h3);
    w0 = n_wv;
    s0 = n_sc;
    p0 = n_pl;
    repeat (200) @(posedge clk);
    chk(16'(n_wv - w0), 16'(n_sc - s0));
    chk(16'(n_pl - p0), 16'h0);
    chk(16'(n_sc - s0 > 10), 16'h1);
    chk(16'(n_sc - s0 >= 19 && n_sc - s0 <= 21), 16'h1);
    wr_reg(16'hFFC1, 4'hC);
    repeat (200) @(posedge clk);
    chk(16'(n_pl - p0 > 5), 16'h1);
    wr_reg(16'hFFC1, 4'h0);
    w0 = n_wv;
    s0 = n_sc;
    repeat (200) @(posedge clk);
    chk(16'(n_wv - w0), 16'h0);
    chk(16'(n_sc - s0 > 10), 16'h1);
    wr_reg(16'hFFC3, 4'h0);
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 4'h0;
    hi_on = 1'b0;
    event_input_pin = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs;
    for (int r = 0; r < 4; r++) period(1, 4'h0, 2'(r), 8'h01, 2 * dv[r]);
    hi_on = 1'b1;
    repeat (100) @(posedge clk);
    period(0, 4'h1, 2'h1, 8'h02, 12);
    period(1, 4'h2, 2'h0, 8'h03, 4);
    period(0, 4'h0, 2'h0, 8'h00, 1);
    t_irq;
    t_hold;
    t_event;
    t_wave;
    report_and_stop;
  end
endmodule // test_dpt_timer

bind dpt_timer dpt_timer_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .shared_output_pin(shared_output_pin), .timer_wave_out(timer_wave_out), .serial_clk(serial_clk),
  .t0_irq_req(t0_irq_req), .t1_irq_req(t1_irq_req), .t0_irq_flag(t0_irq_flag), .t1_irq_flag(t1_irq_flag));
